// ==== hdl/sspm_pkg.sv ====
// Constants, encodings and state types shared by the scratchpad memory access block.
// Assumes a bit-level bus front end on core_clk_i that reports write and read slots.
//
// What this block does
// - Pages are 32 bytes; pages 0 to 15 are free read/write data memory.
// - Pages 16 and 17 hold eight 64-bit secrets, writable, readable only by hash engine.
// - Sixteen 32-bit write counters for pages 8-15 and secrets sit in pages 19, 20.
// - Page 21 counter increments on each hash engine start and saturates at its maximum.
// - The 32-byte scratchpad is page 18 and buffers every data write; secret writes leave it unchanged.
// - Secret n occupies eight bytes from 0200h plus 8n.
// - Write counter for data page 8+k sits at 0260h plus 4k.
// - Write counter for secret n sits at 0280h plus 4n.
// - Target address is loaded as low byte then high byte.
// - Ending offset field holds scratchpad offset of last byte written.
// - Partial byte flag is set when written bit count is not a multiple of eight.
// - Bit 6 of the ending offset/status byte always reads zero.
// - Write data starts at the low five address bits; scratchpad ends at 1Fh.
// - Copied flag sets when a copy is authorised, as it starts; a write command to a permitted address clears it, erase leaves it.
// - A full scratchpad write returns the inverted CRC16 of command, address, data.
// - Scratchpad read sends address low, address high, status, then data.
// - Copy needs exactly both address bytes and status byte matching before copying.
// - Reads of secret pages and scratchpad page return FFh bytes.
// - Parasite power-on reset sets the conceal flag.
// - Scratchpad erase clears the conceal flag and wipes the scratchpad.
// - Regular speed by default; faster speed only after an explicit switch.
// - Command codes: 0Fh write, AAh read, 55h copy of the scratchpad.
// - Erase command C3h fills the whole scratchpad with FFh.
// - Bytes travel least significant bit first in both directions.
// - Write counters saturate at their maximum and never wrap.
package sspm_pkg;

  localparam int          PAGE_BYTES     = 32;
  localparam logic [7:0]  CMD_WRITE_SP   = 8'h0F;
  localparam logic [7:0]  CMD_READ_SP    = 8'hAA;
  localparam logic [7:0]  CMD_COPY_SP    = 8'h55;
  localparam logic [7:0]  CMD_ERASE_SP   = 8'hC3;
  localparam logic [7:0]  CMD_READ_MEM   = 8'hF0;
  localparam logic [15:0] SECRET_BASE    = 16'h0200;
  localparam logic [15:0] SECRET_LAST    = 16'h023F;
  localparam logic [15:0] PAGE_CNT_BASE  = 16'h0260;
  localparam logic [15:0] SEC_CNT_BASE   = 16'h0280;
  localparam logic [15:0] HASH_CNT_BASE  = 16'h02A0;
  localparam logic [15:0] HASH_CNT_LAST  = 16'h02A3;
  localparam logic [4:0]  LAST_OFFSET    = 5'h1F;
  localparam int          ES_AA_BIT      = 7;
  localparam int          ES_PF_BIT      = 5;
  localparam logic [7:0]  ONES_BYTE      = 8'hFF;
  localparam logic [7:0]  ALT_BYTE       = 8'hAA;
  localparam logic [15:0] CRC16_POLY_REV = 16'hA001;
  localparam logic [15:0] CRC16_INIT     = 16'h0000;
  localparam logic [31:0] COUNTER_MAX    = 32'hFFFFFFFF;
  localparam logic [31:0] COUNTER_RESET  = 32'h00000000;

  typedef enum logic [3:0] {
    SSPM_S_CMD, SSPM_S_TA1, SSPM_S_TA2, SSPM_S_WDATA, SSPM_S_CAUTH,
    SSPM_S_COPY, SSPM_S_ERASE, SSPM_S_TX, SSPM_S_IGNORE
  } sspm_state_e;

  typedef enum logic [2:0] {
    SSPM_PH_TA2, SSPM_PH_ES, SSPM_PH_DATA, SSPM_PH_CRC_LO, SSPM_PH_CRC_HI,
    SSPM_PH_ONES, SSPM_PH_MEM, SSPM_PH_ALT
  } sspm_phase_e;

endpackage : sspm_pkg

// ==== hdl/sspm_bit_if.sv ====
// Carrier between the access core, the byte shifter and the CRC generator.
// All signals live on core_clk_i.
`timescale 1ns/10ps
`default_nettype none
interface sspm_bit_if;
  logic       wr_valid;
  logic       wr_bit;
  logic       rd_slot;
  logic       frame_clr;
  logic       byte_valid;
  logic [7:0] rx_byte;
  logic       partial;
  logic       tx_load;
  logic [7:0] tx_byte;
  logic       tx_bit;
  logic       tx_empty;
  logic [15:0] crc;

  modport core (output wr_valid, wr_bit, rd_slot, frame_clr, tx_load, tx_byte,
                input byte_valid, rx_byte, partial, tx_bit, tx_empty, crc);
  modport shifter (input wr_valid, wr_bit, rd_slot, frame_clr, tx_load, tx_byte,
                   output byte_valid, rx_byte, partial, tx_bit, tx_empty);
  modport crcgen (input wr_valid, wr_bit, rd_slot, frame_clr, tx_bit, output crc);
endinterface : sspm_bit_if
`default_nettype wire

// ==== hdl/sspm_shifter.sv ====
// Serial byte shifter: assembles written bits into bytes and serialises reply bytes.
// Assumes at least one idle clock between a tx_empty pulse and the next read slot.
`timescale 1ns/10ps
`default_nettype none
module sspm_shifter
  import sspm_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk_i,
  input  wire logic   resetn_i,
  // Bit carrier
  sspm_bit_if.shifter bus
);

  typedef struct packed {
    logic [7:0] rx;
    logic [2:0] rx_cnt;
    logic       rx_done;
    logic [7:0] tx;
    logic [2:0] tx_cnt;
    logic       tx_done;
  } sspm_shift_s;

  sspm_shift_s st;
  sspm_shift_s next_st;

  always_comb begin
    next_st = st;
    next_st.rx_done = 1'b0;
    next_st.tx_done = 1'b0;
    if (bus.wr_valid) begin
      next_st.rx = {bus.wr_bit, st.rx[7:1]};
      next_st.rx_cnt = st.rx_cnt + 3'd1;
      next_st.rx_done = (st.rx_cnt == 3'd7);
    end
    if (bus.tx_load) begin
      next_st.tx = bus.tx_byte;
      next_st.tx_cnt = 3'd0;
    end else if (bus.rd_slot) begin
      next_st.tx = {1'b1, st.tx[7:1]};
      next_st.tx_cnt = st.tx_cnt + 3'd1;
      next_st.tx_done = (st.tx_cnt == 3'd7);
    end
    if (!resetn_i || bus.frame_clr) begin
      next_st = '{rx: 8'h00, rx_cnt: 3'd0, rx_done: 1'b0,
                  tx: ONES_BYTE, tx_cnt: 3'd0, tx_done: 1'b0};
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  assign bus.byte_valid = st.rx_done;
  assign bus.rx_byte    = st.rx;
  assign bus.partial    = (st.rx_cnt != 3'd0);
  assign bus.tx_bit     = st.tx[0];
  assign bus.tx_empty   = st.tx_done;

endmodule : sspm_shifter
`default_nettype wire

// ==== hdl/sspm_crc16.sv ====
// Bit-serial CRC16 over every bit that crosses the bus, in either direction.
// Cleared at each frame start, so it covers the command code onward.
`timescale 1ns/10ps
`default_nettype none
module sspm_crc16
  import sspm_pkg::*;
(
  // Clock and reset
  input  wire logic  core_clk_i,
  input  wire logic  resetn_i,
  // Bit carrier
  sspm_bit_if.crcgen bus
);

  typedef struct packed {
    logic [15:0] crc;
  } sspm_crc_s;

  sspm_crc_s st;
  sspm_crc_s next_st;
  logic      fb;

  always_comb begin
    next_st = st;
    fb = 1'b0;
    if (bus.wr_valid) begin
      fb = bus.wr_bit ^ st.crc[0];
    end else if (bus.rd_slot) begin
      fb = bus.tx_bit ^ st.crc[0];
    end
    if (bus.wr_valid || bus.rd_slot) begin
      next_st.crc = (st.crc >> 1) ^ (fb ? CRC16_POLY_REV : 16'h0000);
    end
    if (!resetn_i || bus.frame_clr) begin
      next_st.crc = CRC16_INIT;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  assign bus.crc = st.crc;

endmodule : sspm_crc16
`default_nettype wire

// ==== hdl/sspm_core.sv ====
// Scratchpad memory access core: command sequencing, address registers, memories,
// write counters and the conceal and speed flags.
// Assumes a front end on core_clk_i that delivers write slots, read slots and bus resets.
`timescale 1ns/10ps
`default_nettype none
module sspm_core
  import sspm_pkg::*;
#(
  parameter int SCRATCH_BYTES = PAGE_BYTES
)(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Bit-level bus front end
  input  wire logic        wr_bit_valid_i,
  input  wire logic        wr_bit_i,
  input  wire logic        rd_slot_i,
  input  wire logic        bus_reset_i,
  output logic             rd_bit_o,
  // System events
  input  wire logic        por_i,
  input  wire logic        overdrive_req_i,
  input  wire logic        hash_start_i,
  // Hash engine secret port
  input  wire logic [2:0]  hash_secret_sel_i,
  output logic      [63:0] hash_secret_o,
  // Status
  output logic             conceal_flag_o,
  output logic             speed_select_flag_o,
  output logic             copy_authorised_flag_o
);

  if (SCRATCH_BYTES != 32) begin : g_chk
    $error("sspm_core: scratchpad must be 32 bytes");
  end

  // ****************************************************************
  // State and memories
  // ****************************************************************
  typedef struct packed {
    sspm_state_e state;
    sspm_phase_e phase;
    logic [7:0]  cmd;
    logic [15:0] target_address;
    logic [4:0]  ending_offset_bits;
    logic        partial_byte_flag;
    logic        copy_authorised_flag;
    logic        conceal_flag;
    logic        speed_select_flag;
    logic [4:0]  byte_offset_bits;
    logic [4:0]  rd_off;
    logic [1:0]  auth_idx;
    logic        auth_ok;
    logic [4:0]  cp_off;
    logic [15:0] crc_hold;
    logic [63:0] secret_out;
  } sspm_core_s;

  sspm_core_s st;
  sspm_core_s next_st;

  logic [7:0]  data_mem   [512];
  logic [7:0]  secret_mem [64];
  logic [7:0]  scratch    [SCRATCH_BYTES];
  logic [31:0] wr_cnt     [16];
  logic [31:0] hash_start_counter;

  logic        scr_we;
  logic [4:0]  scr_wa;
  logic [7:0]  scr_wd;
  logic        dat_we;
  logic        sec_we;
  logic [15:0] dst_a;
  logic        cnt_inc;
  logic [3:0]  cnt_idx;

  sspm_bit_if bits ();

  sspm_shifter u_shifter (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .bus        (bits.shifter)
  );

  sspm_crc16 u_crc (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .bus        (bits.crcgen)
  );

  // A copy in progress ignores bus resets, so the frame clear is held off then.
  assign bits.wr_valid  = wr_bit_valid_i;
  assign bits.wr_bit    = wr_bit_i;
  assign bits.rd_slot   = rd_slot_i;
  assign bits.frame_clr = bus_reset_i && (st.state != SSPM_S_COPY);

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function automatic logic in_main(input logic [15:0] a);
    return a < SECRET_BASE;
  endfunction : in_main

  function automatic logic in_secret(input logic [15:0] a);
    return (a >= SECRET_BASE) && (a <= SECRET_LAST);
  endfunction : in_secret

  function automatic logic [7:0] es_byte(input sspm_core_s s);
    return {s.copy_authorised_flag, 1'b0, s.partial_byte_flag, s.ending_offset_bits};
  endfunction : es_byte

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    logic [15:0] off;
    off = a - PAGE_CNT_BASE;
    if (in_main(a)) begin
      return data_mem[a[8:0]];
    end else if (a < PAGE_CNT_BASE) begin
      return ONES_BYTE;
    end else if (a < HASH_CNT_BASE) begin
      return wr_cnt[off[5:2]][8*off[1:0] +: 8];
    end else if (a <= HASH_CNT_LAST) begin
      return hash_start_counter[8*a[1:0] +: 8];
    end else begin
      return ONES_BYTE;
    end
  endfunction : mem_byte

  // ****************************************************************
  // Command sequencing
  // ****************************************************************
  always_comb begin
    logic [15:0] addr;
    logic        perm;
    logic [7:0]  expect_b;
    addr     = {bits.rx_byte, st.target_address[7:0]};
    perm     = st.conceal_flag ? in_secret(st.target_address) : in_main(st.target_address);
    expect_b = 8'h00;
    next_st = st;
    bits.tx_load = 1'b0;
    bits.tx_byte = ONES_BYTE;
    scr_we  = 1'b0;
    scr_wa  = st.byte_offset_bits;
    scr_wd  = bits.rx_byte;
    dat_we  = 1'b0;
    sec_we  = 1'b0;
    dst_a   = {st.target_address[15:5], st.cp_off};
    cnt_inc = 1'b0;
    cnt_idx = in_main(st.target_address) ? {1'b0, st.target_address[7:5]}
                                         : {1'b1, st.target_address[5:3]};
    next_st.secret_out = {secret_mem[{hash_secret_sel_i, 3'd7}],
                          secret_mem[{hash_secret_sel_i, 3'd6}],
                          secret_mem[{hash_secret_sel_i, 3'd5}],
                          secret_mem[{hash_secret_sel_i, 3'd4}],
                          secret_mem[{hash_secret_sel_i, 3'd3}],
                          secret_mem[{hash_secret_sel_i, 3'd2}],
                          secret_mem[{hash_secret_sel_i, 3'd1}],
                          secret_mem[{hash_secret_sel_i, 3'd0}]};
    case (st.state)
      SSPM_S_CMD: begin
        if (bits.byte_valid) begin
          next_st.cmd = bits.rx_byte;
          case (bits.rx_byte)
            CMD_WRITE_SP, CMD_ERASE_SP, CMD_READ_MEM: next_st.state = SSPM_S_TA1;
            CMD_READ_SP: begin
              bits.tx_load  = 1'b1;
              bits.tx_byte  = st.target_address[7:0];
              next_st.phase = SSPM_PH_TA2;
              next_st.rd_off = st.target_address[4:0];
              next_st.state = SSPM_S_TX;
            end
            CMD_COPY_SP: begin
              next_st.auth_idx = 2'd0;
              next_st.auth_ok  = 1'b1;
              next_st.state    = SSPM_S_CAUTH;
            end
            default: next_st.state = SSPM_S_IGNORE;
          endcase
        end
      end
      SSPM_S_TA1: begin
        if (bits.byte_valid) begin
          next_st.target_address[7:0] = bits.rx_byte;
          next_st.state = SSPM_S_TA2;
        end
      end
      SSPM_S_TA2: begin
        if (bits.byte_valid) begin
          next_st.target_address = addr;
          next_st.state = SSPM_S_IGNORE;
          if (st.cmd == CMD_WRITE_SP) begin
            if (st.conceal_flag ? in_secret(addr) : in_main(addr)) begin
              next_st.copy_authorised_flag = 1'b0;
              next_st.partial_byte_flag = 1'b0;
              next_st.byte_offset_bits = addr[4:0];
              next_st.ending_offset_bits = addr[4:0];
              next_st.state = SSPM_S_WDATA;
            end
          end else if (st.cmd == CMD_ERASE_SP) begin
            next_st.cp_off = 5'd0;
            bits.tx_load   = 1'b1;
            next_st.state  = SSPM_S_ERASE;
          end else begin
            bits.tx_load   = 1'b1;
            bits.tx_byte   = mem_byte(addr);
            next_st.phase  = SSPM_PH_MEM;
            next_st.state  = SSPM_S_TX;
          end
        end
      end
      SSPM_S_WDATA: begin
        if (bits.byte_valid) begin
          scr_we = !st.conceal_flag;
          next_st.ending_offset_bits = st.byte_offset_bits;
          next_st.byte_offset_bits = st.byte_offset_bits + 5'd1;
          if (st.byte_offset_bits == LAST_OFFSET) begin
            next_st.crc_hold = ~bits.crc;
            bits.tx_load  = 1'b1;
            bits.tx_byte  = ~bits.crc[7:0];
            next_st.phase = SSPM_PH_CRC_HI;
            next_st.state = SSPM_S_TX;
          end
        end
      end
      SSPM_S_CAUTH: begin
        case (st.auth_idx)
          2'd0:    expect_b = st.target_address[7:0];
          2'd1:    expect_b = st.target_address[15:8];
          default: expect_b = es_byte(st);
        endcase
        if (bits.byte_valid) begin
          next_st.auth_ok  = st.auth_ok && (bits.rx_byte == expect_b);
          next_st.auth_idx = st.auth_idx + 2'd1;
          if (st.auth_idx == 2'd2) begin
            bits.tx_load  = 1'b1;
            next_st.phase = SSPM_PH_ONES;
            next_st.state = SSPM_S_TX;
            if (next_st.auth_ok && perm) begin
              next_st.copy_authorised_flag = 1'b1;
              next_st.cp_off = st.target_address[4:0];
              next_st.state  = SSPM_S_COPY;
            end
          end
        end
      end
      SSPM_S_COPY: begin
        dat_we = in_main(st.target_address);
        sec_we = in_secret(st.target_address);
        if (st.cp_off == st.ending_offset_bits) begin
          cnt_inc = dat_we ? st.target_address[8] : 1'b1;
          next_st.phase = SSPM_PH_ALT;
          next_st.state = SSPM_S_TX;
        end else begin
          next_st.cp_off = st.cp_off + 5'd1;
        end
      end
      SSPM_S_ERASE: begin
        scr_we = 1'b1;
        scr_wa = st.cp_off;
        scr_wd = ONES_BYTE;
        next_st.cp_off = st.cp_off + 5'd1;
        if (st.cp_off == LAST_OFFSET) begin
          next_st.conceal_flag = 1'b0;
          next_st.phase = SSPM_PH_ALT;
          next_st.state = SSPM_S_TX;
        end
      end
      SSPM_S_TX: begin
        if (bits.tx_empty) begin
          bits.tx_load = 1'b1;
          case (st.phase)
            SSPM_PH_TA2: begin
              bits.tx_byte  = st.target_address[15:8];
              next_st.phase = SSPM_PH_ES;
            end
            SSPM_PH_ES: begin
              bits.tx_byte  = es_byte(st);
              next_st.phase = SSPM_PH_DATA;
            end
            SSPM_PH_DATA: begin
              bits.tx_byte = st.conceal_flag ? ONES_BYTE : scratch[st.rd_off];
              next_st.rd_off = st.rd_off + 5'd1;
              if (st.rd_off == LAST_OFFSET) begin
                next_st.phase = SSPM_PH_CRC_LO;
              end
            end
            SSPM_PH_CRC_LO: begin
              next_st.crc_hold = ~bits.crc;
              bits.tx_byte  = ~bits.crc[7:0];
              next_st.phase = SSPM_PH_CRC_HI;
            end
            SSPM_PH_CRC_HI: begin
              bits.tx_byte  = st.crc_hold[15:8];
              next_st.phase = SSPM_PH_ONES;
            end
            SSPM_PH_MEM: begin
              next_st.target_address = st.target_address + 16'd1;
              bits.tx_byte = mem_byte(st.target_address + 16'd1);
            end
            SSPM_PH_ALT: bits.tx_byte = ALT_BYTE;
            default:     bits.tx_byte = ONES_BYTE;
          endcase
        end
      end
      default: ;
    endcase
    if (bus_reset_i && (st.state != SSPM_S_COPY)) begin
      if ((st.state == SSPM_S_WDATA) && bits.partial) begin
        next_st.partial_byte_flag = 1'b1;
      end
      next_st.state = SSPM_S_CMD;
    end
    if (overdrive_req_i) begin
      next_st.speed_select_flag = 1'b1;
    end
    if (por_i) begin
      next_st.conceal_flag = 1'b1;
    end
    if (!resetn_i) begin
      next_st = '0;
      next_st.state = SSPM_S_CMD;
      next_st.phase = SSPM_PH_ONES;
      next_st.conceal_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  // ****************************************************************
  // Memory arrays
  // ****************************************************************
  // Data, secrets and scratchpad model nonvolatile storage and take no reset.
  always_ff @(posedge core_clk_i) begin
    if (scr_we) begin
      scratch[scr_wa] <= scr_wd;
    end
    if (dat_we) begin
      data_mem[dst_a[8:0]] <= scratch[st.cp_off];
    end
    if (sec_we) begin
      secret_mem[dst_a[5:0]] <= scratch[st.cp_off];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 16; i++) begin
        wr_cnt[i] <= COUNTER_RESET;
      end
      hash_start_counter <= COUNTER_RESET;
    end else begin
      if (cnt_inc && (wr_cnt[cnt_idx] != COUNTER_MAX)) begin
        wr_cnt[cnt_idx] <= wr_cnt[cnt_idx] + 32'd1;
      end
      if (hash_start_i && (hash_start_counter != COUNTER_MAX)) begin
        hash_start_counter <= hash_start_counter + 32'd1;
      end
    end
  end

  assign rd_bit_o               = bits.tx_bit;
  assign hash_secret_o          = st.secret_out;
  assign conceal_flag_o         = st.conceal_flag;
  assign speed_select_flag_o    = st.speed_select_flag;
  assign copy_authorised_flag_o = st.copy_authorised_flag;

endmodule : sspm_core
`default_nettype wire

// ==== verif/sspm_asserts.sv ====
// Checker on the core's flag outputs, bound to the core's ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sspm_asserts (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic wr_bit_valid_i,
  input wire logic por_i,
  input wire logic overdrive_req_i,
  input wire logic conceal_flag_o,
  input wire logic speed_select_flag_o,
  input wire logic copy_authorised_flag_o
);
  logic [5:0] quiet;
  // Conceal clearing follows a written byte within 40 cycles and copy flag changes within a few, so count the silence.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || wr_bit_valid_i) quiet <= 6'h00;
    else if (quiet != 6'h3F) quiet <= quiet + 6'h01;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_rst; $rose(resetn_i) |-> conceal_flag_o && !copy_authorised_flag_o; endproperty
  a_rst: assert property (p_rst) else $error("flags wrong after reset");
  property p_por; por_i |=> conceal_flag_o; endproperty
  a_por: assert property (p_por) else $error("conceal not set");
  property p_od; overdrive_req_i |=> speed_select_flag_o[*3]; endproperty
  a_od: assert property (p_od) else $error("speed not set");
  property p_odr; $rose(speed_select_flag_o) |-> $past(overdrive_req_i); endproperty
  a_odr: assert property (p_odr) else $error("speed set unasked");
  property p_odf; $rose(resetn_i) |-> !speed_select_flag_o; endproperty
  a_odf: assert property (p_odf) else $error("speed not regular");
  property p_cf; $fell(conceal_flag_o) |-> quiet <= 40; endproperty
  a_cf: assert property (p_cf) else $error("conceal cleared late");
  property p_aar; $rose(copy_authorised_flag_o) |-> quiet <= 4; endproperty
  a_aar: assert property (p_aar) else $error("auth set late");
  property p_aaf; $fell(copy_authorised_flag_o) |-> quiet <= 4; endproperty
  a_aaf: assert property (p_aaf) else $error("auth cleared late");
  c_aa: cover property ($rose(copy_authorised_flag_o));
  c_cf: cover property ($fell(conceal_flag_o));
  c_od: cover property ($rose(speed_select_flag_o));
endmodule : sspm_asserts
bind sspm_core sspm_asserts sspm_asserts_inst (.core_clk_i, .resetn_i, .wr_bit_valid_i,
  .por_i, .overdrive_req_i, .conceal_flag_o, .speed_select_flag_o, .copy_authorised_flag_o);
`default_nettype wire

// ==== verif/sspm_mst.sv ====
// Bus master model: write slots, read slots and bus resets at bit level.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module sspm_mst (
  input  wire logic core_clk_i,
  input  wire logic rd_bit_i,
  output logic      wr_bit_valid_o,
  output logic      wr_bit_o,
  output logic      rd_slot_o,
  output logic      bus_reset_o
);
  initial begin
    wr_bit_valid_o = 1'b0;
    wr_bit_o = 1'b1;
    rd_slot_o = 1'b0;
    bus_reset_o = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : idle
  // Five cycles a slot keeps well above the minimum spacing.
  task automatic put_bit(input logic b);
    wr_bit_o = b;
    wr_bit_valid_o = 1'b1;
    idle(1);
    wr_bit_valid_o = 1'b0;
    wr_bit_o = ~b;
    idle(4);
  endtask : put_bit
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) put_bit(b[i]);
  endtask : send
  task automatic recv(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rd_slot_o = 1'b1;
      b[i] = rd_bit_i;
      @(posedge core_clk_i);
      #1;
      rd_slot_o = 1'b0;
      idle(4);
    end
  endtask : recv
  task automatic breset;
    bus_reset_o = 1'b1;
    idle(1);
    bus_reset_o = 1'b0;
    idle(4);
  endtask : breset
endmodule : sspm_mst
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the scratchpad access core.
// Assumes the core is the block's top and the master model drives its bit link.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sspm_pkg::*;
;
  logic        core_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        por_i = 1'b0;
  logic        overdrive_req_i = 1'b0;
  logic        hash_start_i = 1'b0;
  logic        wr_bit_valid_i, wr_bit_i, rd_slot_i, bus_reset_i, rd_bit_o;
  logic        conceal_flag_o, speed_select_flag_o, copy_authorised_flag_o;
  logic [15:0] crc;
  logic [63:0] hash_secret_o;
  logic [2:0]  hash_secret_sel;
  int          n_errors = 0;
  int          total_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  sspm_core sspm_core_inst (.core_clk_i, .resetn_i, .wr_bit_valid_i, .wr_bit_i, .rd_slot_i,
    .bus_reset_i, .rd_bit_o, .por_i, .overdrive_req_i, .hash_start_i,
    .hash_secret_sel_i(hash_secret_sel), .hash_secret_o, .conceal_flag_o, .speed_select_flag_o,
    .copy_authorised_flag_o);
  sspm_mst sspm_mst_inst (.core_clk_i, .rd_bit_i(rd_bit_o), .wr_bit_valid_o(wr_bit_valid_i),
    .wr_bit_o(wr_bit_i), .rd_slot_o(rd_slot_i), .bus_reset_o(bus_reset_i));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? CRC16_POLY_REV : 16'h0000);
    return c;
  endfunction : crc_upd
  task automatic tx(input logic [7:0] b);
    sspm_mst_inst.send(b);
    crc = crc_upd(crc, b);
  endtask : tx
  task automatic rx(input string w, input logic [7:0] e);
    logic [7:0] g;
    sspm_mst_inst.recv(g);
    crc = crc_upd(crc, g);
    chk(w, e, g);
  endtask : rx
  task automatic rx_crc;
    logic [15:0] e;
    e = ~crc;
    rx("crc low", e[7:0]);
    rx("crc high", e[15:8]);
  endtask : rx_crc
  task automatic frame(input logic [7:0] c, input logic [15:0] a);
    sspm_mst_inst.breset();
    crc = CRC16_INIT;
    tx(c);
    if (c != CMD_READ_SP) tx(a[7:0]);
    if (c != CMD_READ_SP) tx(a[15:8]);
  endtask : frame
  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_erase;
    chk("conceal", 8'h01, {7'h00, conceal_flag_o});
    frame(CMD_ERASE_SP, 16'h0105);
    sspm_mst_inst.idle(45);
    chk("conceal", 8'h00, {7'h00, conceal_flag_o});
    rx("erase busy", ONES_BYTE);
    rx("erase done", ALT_BYTE);
  endtask : t_erase
  task automatic t_write;
    frame(CMD_WRITE_SP, 16'h013C);
    for (int k = 0; k < 4; k++) tx(8'hA0 + 8'(k));
    sspm_mst_inst.send(8'h5A);
    rx_crc();
    rx("after crc", ONES_BYTE);
  endtask : t_write
  task automatic t_read;
    frame(CMD_READ_SP, 16'h0000);
    rx("ta low", 8'h3C);
    rx("ta high", 8'h01);
    rx("status", 8'h1F);
    for (int k = 0; k < 4; k++) rx("scratch", 8'hA0 + 8'(k));
    rx_crc();
  endtask : t_read
  task automatic t_copy;
    frame(CMD_COPY_SP, 16'h013C);
    tx(8'h1F);
    sspm_mst_inst.idle(40);
    chk("auth", 8'h01, {7'h00, copy_authorised_flag_o});
    rx("copy busy", ONES_BYTE);
    rx("copy done", ALT_BYTE);
    frame(CMD_READ_MEM, 16'h013C);
    for (int k = 0; k < 4; k++) rx("memory", 8'hA0 + 8'(k));
    frame(CMD_READ_MEM, PAGE_CNT_BASE + 16'h0004);
    rx("page count", 8'h01);
    for (int k = 0; k < 3; k++) rx("page count", 8'h00);
    hash_start_i = 1'b1;
    sspm_mst_inst.idle(1);
    hash_start_i = 1'b0;
    frame(CMD_READ_MEM, HASH_CNT_BASE);
    rx("hash count", 8'h01);
    frame(CMD_READ_MEM, SECRET_BASE + 16'h0008);
    rx("secret", ONES_BYTE);
  endtask : t_copy
  task automatic t_partial;
    frame(CMD_WRITE_SP, 16'h0100);
    tx(8'h55);
    for (int i = 0; i < 3; i++) sspm_mst_inst.put_bit(1'b1);
    frame(CMD_READ_SP, 16'h0000);
    rx("ta low", 8'h00);
    rx("ta high", 8'h01);
    rx("status", 8'h20);
  endtask : t_partial
  task automatic t_flags;
    chk("speed", 8'h00, {7'h00, speed_select_flag_o});
    overdrive_req_i = 1'b1;
    por_i = 1'b1;
    sspm_mst_inst.idle(1);
    overdrive_req_i = 1'b0;
    por_i = 1'b0;
    sspm_mst_inst.idle(2);
    chk("speed", 8'h01, {7'h00, speed_select_flag_o});
    chk("conceal", 8'h01, {7'h00, conceal_flag_o});
    hash_secret_sel = 3'h7;
    frame(CMD_WRITE_SP, 16'h0238);
    for (int k = 0; k < 8; k++) tx(8'h00);
    frame(CMD_COPY_SP, 16'h0238);
    tx(8'h1F);
    sspm_mst_inst.idle(12);
    for (int k = 0; k < 8; k++)
      chk("hash secret", (k < 4) ? ONES_BYTE : 8'hA0 + 8'(k - 4), hash_secret_o[8*k +: 8]);
    frame(CMD_READ_MEM, SEC_CNT_BASE + 16'h001C);
    rx("secret count", 8'h01);
  endtask : t_flags
  initial begin
    repeat (6) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    t_erase();
    t_write();
    t_read();
    t_copy();
    t_partial();
    t_flags();
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_errors++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
